// *** hw/crju_decode.sv ***
// crju_decode: classifies a 16-bit instruction word for the jump unit
// assumes the word is already aligned into the low half by fetch
`timescale 1ns/1ns
module crju_decode
	import crju_pkg::*;
(
	// instruction
	input  wire logic [15:0]         i_instr,
	// classification
	output crju_pkg::crju_op_e       o_op,
	output logic [crju_pkg::REG_AW-1:0] o_src
);
	////////////////////////////////////////////////////////////////////////
	// opcode group then function field select the operation
	always_comb
	begin
		o_src = i_instr[SRC_HI:SRC_LO];
		o_op  = CRJU_OP_NONE;
		if (i_instr[OPC_HI:OPC_LO] == OPC_GROUP_C)
		begin
			case (i_instr[FN_HI:FN_LO])
				FN_JUMP:       o_op = CRJU_OP_JUMP;
				FN_JUMP_LINK:  o_op = CRJU_OP_LINK;
				FN_JUMP_STACK: o_op = CRJU_OP_STACK;
				FN_BREAK:      o_op = CRJU_OP_BREAK;
				default:       o_op = CRJU_OP_NONE;
			endcase
		end
	end
endmodule // crju_decode

// *** hw/crju_unit.sv ***
// crju_unit: execution and redirect logic for compact register jumps
// assumes the register file read ports answer combinationally and
// that the pipeline honours o_flush and the write-back strobes
`timescale 1ns/1ns
module crju_unit
	import crju_pkg::*;
#(
	parameter bit COMPACT_ONLY = 1'b0   // strap: core lacks the 32-bit set
)
(
	// clock and reset
	input  wire logic                        i_mclk,
	input  wire logic                        i_rst_n,
	// issue
	input  wire logic                        i_valid,
	input  wire logic [15:0]                 i_instr,
	input  wire logic [crju_pkg::XLEN-1:0]   i_pc,
	// register file read
	output logic [crju_pkg::REG_AW-1:0]      o_rd_addr_a,
	input  wire logic [crju_pkg::XLEN-1:0]   i_rd_data_a,
	output logic [crju_pkg::REG_AW-1:0]      o_rd_addr_b,
	input  wire logic [crju_pkg::XLEN-1:0]   i_rd_data_b,
	// register file write
	output logic                             o_wr_en,
	output logic [crju_pkg::REG_AW-1:0]      o_wr_addr,
	output logic [crju_pkg::XLEN-1:0]        o_wr_data,
	// redirect to fetch
	output logic                             o_redirect,
	output logic [crju_pkg::XLEN-1:0]        o_target,
	output logic                             o_flush,
	output logic                             o_mode,
	// exceptions
	output logic                             o_break_exc,
	output logic                             o_fetch_addr_err
);
	////////////////////////////////////////////////////////////////////////
	// decode
	crju_op_e               op;
	logic [REG_AW-1:0]      src;

	crju_decode u_dec
	(
		.i_instr (i_instr),
		.o_op    (op),
		.o_src   (src)
	);

	////////////////////////////////////////////////////////////////////////
	// operand selection: stack jump reads return reg and stack reg
	logic                   is_jump;
	logic [XLEN-1:0]        tgt_raw;
	logic [XLEN-1:0]        sp_sum;
	logic [XLEN-1:0]        sp_imm;

	assign is_jump     = i_valid && (op == CRJU_OP_JUMP || op == CRJU_OP_LINK
	                                 || op == CRJU_OP_STACK);
	assign o_rd_addr_a = (op == CRJU_OP_STACK) ? REG_LINK : src;
	assign o_rd_addr_b = REG_STACK;
	// target read in the issue cycle, one cycle before the registered link write, so rs=31 sees old value
	assign tgt_raw     = i_rd_data_a;
	assign sp_imm      = XLEN'({src, {IMM_SHIFT{1'b0}}});
	// plain wrap: carry out dropped on purpose, no overflow trap
	assign sp_sum      = i_rd_data_b + sp_imm;

	////////////////////////////////////////////////////////////////////////
	// registered outputs
	logic                   redir_q, redir_d;
	logic [XLEN-1:0]        tgt_q, tgt_d;
	logic                   mode_q, mode_d;
	logic                   aerr_q, aerr_d;
	logic                   brk_q, brk_d;
	logic                   wen_q, wen_d;
	logic [REG_AW-1:0]      waddr_q, waddr_d;
	logic [XLEN-1:0]        wdata_q, wdata_d;

	// next-state for redirect, mode, exceptions and write-back
	always_comb
	begin
		redir_d = 1'b0;
		tgt_d   = tgt_q;
		mode_d  = mode_q;
		aerr_d  = 1'b0;
		brk_d   = 1'b0;
		wen_d   = 1'b0;
		waddr_d = waddr_q;
		wdata_d = wdata_q;
		if (i_valid && op == CRJU_OP_BREAK)
			brk_d = 1'b1;
		else if (is_jump)
		begin
			redir_d = 1'b1;
			tgt_d   = {tgt_raw[XLEN-1:1], 1'b0};
			if (COMPACT_ONLY)
				aerr_d = ~tgt_raw[0];
			else
			begin
				mode_d = tgt_raw[0];
				aerr_d = ~tgt_raw[0] && tgt_raw[1];
			end
			if (op == CRJU_OP_LINK)
			begin
				wen_d   = 1'b1;
				waddr_d = REG_LINK;
				wdata_d = i_pc + INSTR_BYTES;
			end
			else if (op == CRJU_OP_STACK)
			begin
				wen_d   = 1'b1;
				waddr_d = REG_STACK;
				wdata_d = sp_sum;
			end
		end
	end

	// registers only; synchronous reset
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			redir_q <= 1'b0;
			tgt_q   <= RESET_PC;
			mode_q  <= RESET_MODE;
			aerr_q  <= 1'b0;
			brk_q   <= 1'b0;
			wen_q   <= 1'b0;
			waddr_q <= '0;
			wdata_q <= '0;
		end
		else
		begin
			redir_q <= redir_d;
			tgt_q   <= tgt_d;
			mode_q  <= mode_d;
			aerr_q  <= aerr_d;
			brk_q   <= brk_d;
			wen_q   <= wen_d;
			waddr_q <= waddr_d;
			wdata_q <= wdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs; flush squashes the sequential successor of a jump or break
	assign o_redirect       = redir_q;
	assign o_target         = tgt_q;
	assign o_mode           = COMPACT_ONLY ? 1'b1 : mode_q;
	assign o_flush          = redir_q | brk_q;
	assign o_break_exc      = brk_q;
	// error travels with the redirect, so fetch raises it at the target
	assign o_fetch_addr_err = aerr_q;
	assign o_wr_en          = wen_q;
	assign o_wr_addr        = waddr_q;
	assign o_wr_data        = wdata_q;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);

	break_raise_a: assert property (i_valid && op == CRJU_OP_BREAK |=> o_break_exc && !o_redirect)
		else $error("breakpoint not raised");
	target_load_a: assert property (is_jump |=> o_redirect && o_target[31:1] == $past(tgt_raw[31:1]))
		else $error("jump target wrong");
	target_lsb_a: assert property (o_redirect |-> !o_target[0])
		else $error("target bit 0 not cleared");
	addr_err_a: assert property (is_jump |=> o_fetch_addr_err == (COMPACT_ONLY ? !$past(tgt_raw[0])
	                            : (!$past(tgt_raw[0]) && $past(tgt_raw[1]))))
		else $error("address error wrong");
	mode_copy_a: assert property (is_jump && !COMPACT_ONLY |=> o_mode == $past(tgt_raw[0]))
		else $error("mode bit not copied");
	dual_err_a: assert property (o_fetch_addr_err && !COMPACT_ONLY |-> !o_mode && o_target[1])
		else $error("dual-set error without cause");
	link_write_a: assert property (i_valid && op == CRJU_OP_LINK |=> o_wr_en && o_wr_addr == REG_LINK
	                             && o_wr_data == $past(i_pc) + INSTR_BYTES)
		else $error("link write wrong");
	stack_write_a: assert property (i_valid && op == CRJU_OP_STACK |=> o_wr_en && o_wr_addr == REG_STACK
	                              && o_wr_data == $past(sp_sum))
		else $error("stack update wrong");
	no_slot_a: assert property (o_redirect |-> o_flush)
		else $error("delay slot not squashed");
	back_to_back_a: assert property (is_jump ##1 is_jump |=> o_redirect)
		else $error("second jump dropped");

	cov_jump_c:  cover property (i_valid && op == CRJU_OP_JUMP);
	cov_link_c:  cover property (i_valid && op == CRJU_OP_LINK && src == REG_LINK);
	cov_stack_c: cover property (i_valid && op == CRJU_OP_STACK);
	cov_err_c:   cover property (o_fetch_addr_err);
endmodule // crju_unit

// *** pkg/crju_pkg.sv ***
// crju_pkg: constants for the compact register-jump unit
// assumes a 32-bit core with a 32-entry general register file
package crju_pkg;
	localparam int          XLEN          = 32;
	localparam int          REG_AW        = 5;
	// major opcode field, source field and compact-group function field
	localparam int          OPC_HI        = 15;
	localparam int          OPC_LO        = 10;
	localparam int          SRC_HI        = 9;
	localparam int          SRC_LO        = 5;
	localparam int          FN_HI         = 4;
	localparam int          FN_LO         = 0;
	localparam logic [5:0]  OPC_GROUP_C   = 6'h11;   // 010001
	localparam logic [4:0]  FN_JUMP       = 5'h03;   // 00011
	localparam logic [4:0]  FN_JUMP_LINK  = 5'h0B;
	localparam logic [4:0]  FN_JUMP_STACK = 5'h13;
	localparam logic [4:0]  FN_BREAK      = 5'h1B;
	// fixed registers
	localparam logic [4:0]  REG_LINK      = 5'd31;
	localparam logic [4:0]  REG_STACK     = 5'd29;
	// immediate of the stack-adjusting jump sits in the source field
	localparam int          IMM_SHIFT     = 2;
	localparam logic [31:0] INSTR_BYTES   = 32'h0000_0002;
	// reset values
	localparam logic [31:0] RESET_PC      = 32'h0000_0000;
	localparam logic        RESET_MODE    = 1'b1;

	typedef enum logic [2:0] {
		CRJU_OP_NONE,
		CRJU_OP_JUMP,
		CRJU_OP_LINK,
		CRJU_OP_STACK,
		CRJU_OP_BREAK
	} crju_op_e;
endpackage

// *** sim/crju_unit_bench.sv ***
// crju_unit_bench: directed bench for the compact register-jump unit
// assumes a comb register file model answers the two read ports
`timescale 1ns/1ns
module crju_unit_bench;
	import crju_pkg::*;
	logic             i_mclk;
	logic             i_rst_n;
	logic             i_valid;
	logic [15:0]      i_instr;
	logic [XLEN-1:0]  i_pc;
	logic [XLEN-1:0]  rf [32];
	logic [4:0]       addr_a, addr_b, wr_addr, addr_c;
	logic [XLEN-1:0]  wr_data, target, target_c;
	logic             wr_en, redirect, flush, mode, brk, err, mode_c, err_c;
	int               fail_count, total_checks, cycles;
	////////////////////////////////////////////////////////////////
	// dual-set core and compact-only core share every input
	crju_unit #(.COMPACT_ONLY(1'b0)) u_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
		.i_valid(i_valid), .i_instr(i_instr), .i_pc(i_pc), .o_rd_addr_a(addr_a),
		.i_rd_data_a(rf[addr_a]), .o_rd_addr_b(addr_b), .i_rd_data_b(rf[addr_b]),
		.o_wr_en(wr_en), .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_redirect(redirect),
		.o_target(target), .o_flush(flush), .o_mode(mode), .o_break_exc(brk),
		.o_fetch_addr_err(err));
	crju_unit #(.COMPACT_ONLY(1'b1)) u_dut_c (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
		.i_valid(i_valid), .i_instr(i_instr), .i_pc(i_pc), .o_rd_addr_a(addr_c),
		.i_rd_data_a(rf[addr_c]), .o_rd_addr_b(), .i_rd_data_b(rf[29]), .o_wr_en(),
		.o_wr_addr(), .o_wr_data(), .o_redirect(), .o_target(target_c), .o_flush(),
		.o_mode(mode_c), .o_break_exc(), .o_fetch_addr_err(err_c));
	////////////////////////////////////////////////////////////////
	// clock and hang guard; 2000 cycles is far beyond the directed run
	initial
	begin
		i_mclk = 1'b0;
		forever #25 i_mclk = ~i_mclk;
	end
	always @(posedge i_mclk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			fail_count++;
			summarize();
		end
	end
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// wide enough for the mode or strobe bits packed above a full target word
	task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one word issued, answer sampled after the following edge settles
	task automatic run(input logic [15:0] w, input logic [31:0] pc);
		@(posedge i_mclk);
		i_valid <= 1'b1;
		i_instr <= w;
		i_pc <= pc;
		@(posedge i_mclk);
		i_valid <= 1'b0;
		#1;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_plain();
		rf[5] <= 32'h1234_5679;
		run({OPC_GROUP_C, 5'h05, FN_JUMP}, 32'h0000_0040);
		cmp(target, 32'h1234_5678);
		cmp(mode, 1'b1);
		cmp({redirect, flush, wr_en, brk}, 4'hC);
		cmp(target_c, 32'h1234_5678);
		cmp({err, err_c, mode_c}, 3'h1);
		cmp(addr_a, 5'h05);
	endtask
	task automatic t_align();
		rf[6] <= 32'h0000_1002;
		run({OPC_GROUP_C, 5'h06, FN_JUMP}, 32'h0000_0080);
		cmp({mode, target}, {1'b0, 32'h0000_1002});
		cmp(err, 1'b1);
		cmp(err_c, 1'b1);
		rf[6] <= 32'h0000_1004;
		run({OPC_GROUP_C, 5'h06, FN_JUMP}, 32'h0000_0082);
		cmp(err, 1'b0);
	endtask
	task automatic t_link();
		rf[31] <= 32'h8000_0011;
		run({OPC_GROUP_C, 5'h1F, FN_JUMP_LINK}, 32'h0000_0100);
		cmp(target, 32'h8000_0010);
		cmp({wr_en, wr_addr}, {1'b1, 5'h1F});
		cmp(wr_data, 32'h0000_0102);
	endtask
	// sum wraps past the top of the address space
	task automatic t_stack();
		rf[31] <= 32'h0000_2001;
		rf[29] <= 32'hFFFF_FFF0;
		run({OPC_GROUP_C, 5'h1F, FN_JUMP_STACK}, 32'h0000_0200);
		cmp({redirect, target}, {1'b1, 32'h0000_2000});
		cmp({wr_en, wr_addr}, {1'b1, 5'h1D});
		cmp({addr_a, addr_b}, {5'h1F, 5'h1D});
		cmp(wr_data, 32'h0000_006C);
	endtask
	task automatic t_break();
		run({OPC_GROUP_C, 5'h00, FN_BREAK}, 32'h0000_0300);
		cmp({brk, flush, redirect, wr_en}, 4'hC);
	endtask
	// jump followed at once by a link, no bubble between them
	task automatic t_b2b();
		rf[7] <= 32'h0000_0301;
		rf[8] <= 32'h4000_0001;
		@(posedge i_mclk);
		i_valid <= 1'b1;
		i_instr <= {OPC_GROUP_C, 5'h07, FN_JUMP};
		@(posedge i_mclk);
		i_instr <= {OPC_GROUP_C, 5'h08, FN_JUMP_LINK};
		i_pc <= 32'h0000_0400;
		#1;
		cmp({redirect, wr_en, target}, {2'h2, 32'h0000_0300});
		@(posedge i_mclk);
		i_valid <= 1'b0;
		#1;
		cmp({redirect, wr_en, target}, {2'h3, 32'h4000_0000});
		cmp(wr_data, 32'h0000_0402);
	endtask
	task automatic t_miss();
		run({6'h10, 5'h05, FN_JUMP}, 32'h0000_0500);
		cmp({redirect, flush, wr_en, brk, err}, 5'h00);
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		i_rst_n = 1'b0;
		i_valid = 1'b0;
		i_instr = 16'h0000;
		i_pc = 32'h0000_0000;
		for (int k = 0; k < 32; k++)
			rf[k] = 32'h0000_0000;
		repeat (2) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		#1;
		cmp({mode, redirect, flush, wr_en, brk, err}, 6'h20);
		cmp(target, 32'h0000_0000);
		t_plain();
		t_align();
		t_link();
		t_stack();
		t_break();
		t_b2b();
		t_miss();
		summarize();
	end
endmodule // crju_unit_bench
